// File: inc/ioxp_pkg.sv
// Operation
// - Sixteen lines in two 8-bit ports, each with input, output, inversion, direction.
// - Master writes direction bits; each line is then input or driven output.
// - Input register captures line levels; outputs are driven from latched output register.
// - A set inversion bit returns that line's level inverted on input reads.
// - Every register, direction, output and inversion included, reads back its contents.
// - Alert asserts while any input differs from its last registered state.
// - Alert is active-low open-drain: pulls low when asserted, released otherwise.
// - Power-on reset loads register defaults and returns the state machine home.
// - After power-on all sixteen lines are inputs; nothing is driven.
// - Three select inputs set the low address bits; eight devices share a bus.
// - Serial interface works at bus clocks up to 400 kHz.
// - Short noise pulses on serial clock and data are filtered before sampling.
// - Input registers at 0 and 1, outputs at 2 and 3, directions 6 and 7.
package ioxp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [2:0] REG_IN0 = 3'h0;
  localparam logic [2:0] REG_IN1 = 3'h1;
  localparam logic [2:0] REG_OUT0 = 3'h2;
  localparam logic [2:0] REG_OUT1 = 3'h3;
  localparam logic [2:0] REG_POL0 = 3'h4;
  localparam logic [2:0] REG_POL1 = 3'h5;
  localparam logic [2:0] REG_DIR0 = 3'h6;
  localparam logic [2:0] REG_DIR1 = 3'h7;

  localparam logic [7:0] OUT_RST = 8'hff;
  localparam logic [7:0] POL_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hff;

  // Fixed upper part of the bus address; a plain default.
  localparam logic [3:0] ADDR_FIXED = 4'h4;

  ////////////////////////////////////////////////////////////////////////////
  localparam int CLK_NS = 25;
  localparam int SPIKE_NS = 50;
  localparam int FILT_CYC_I = ((SPIKE_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : ((SPIKE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [1:0] FILT_CYC = FILT_CYC_I[1:0];
  localparam int SCL_MAX_KHZ = 400;
  localparam int SYNC_W = 19;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {S_IDLE, S_ADDR, S_ACK_A, S_PTR, S_ACK_W, S_WDATA, S_TX, S_RACK} ioxp_fsm_t;

  typedef logic [1:0][7:0] ioxp_lines_t;

  typedef struct packed {
    ioxp_lines_t out;
    ioxp_lines_t oe;
  } ioxp_pinout_t;

  typedef struct packed {
    logic out;
    logic oe;
  } ioxp_od_t;

  typedef struct packed {
    ioxp_fsm_t fsm;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic mack;
    logic [2:0] ptr;
    ioxp_lines_t outl;
    ioxp_lines_t pol;
    ioxp_lines_t dir;
    ioxp_lines_t snap;
    logic primed;
    logic sda_oe;
    logic alert;
    logic scl_q;
    logic sda_q;
  } ioxp_state_t;

  typedef struct packed {
    logic [1:0] sync;
    logic [1:0] cnt;
    logic out;
  } ioxp_filt_t;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
  } ioxp_sync_t;

endpackage : ioxp_pkg

// File: src/ioxp_sync2.sv
module ioxp_sync2 (
  // Clock and reset
  input logic ref_clk,
  input logic rst_n,
  // Pin levels
  input logic [ioxp_pkg::SYNC_W-1:0] d,
  output logic [ioxp_pkg::SYNC_W-1:0] q
);
  import ioxp_pkg::*;

  ioxp_sync_t st;
  ioxp_sync_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // The first stage feeds only the second, so metastability stays contained.
  always_comb
  begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign q = st.s2;

endmodule : ioxp_sync2

// File: src/ioxp_glitch_filter.sv
module ioxp_glitch_filter (
  // Clock and reset
  input logic ref_clk,
  input logic rst_n,
  // Bus wire
  input logic raw,
  output logic filt
);
  import ioxp_pkg::*;

  ioxp_filt_t st;
  ioxp_filt_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // spike rejection
  always_comb
  begin
    next_st = st;
    next_st.sync = {st.sync[0], raw};
    if (st.sync[1] == st.out)
      next_st.cnt = 2'h0;
    else if (st.cnt == FILT_CYC - 2'h1)
    begin
      next_st.out = st.sync[1];
      next_st.cnt = 2'h0;
    end
    else
      next_st.cnt = st.cnt + 2'h1;
  end

  // The idle bus is high, so reset to high to avoid a false start.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '{sync: 2'h3, cnt: 2'h0, out: 1'b1};
    else
      st <= next_st;
  end

  assign filt = st.out;

  ////////////////////////////////////////////////////////////////////////////
  property p_filt_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    $changed(st.out) |-> ($past(st.sync[1]) != $past(st.out)) && ($past(st.sync[1], 2) != $past(st.out, 2));
  endproperty
  a_filt_hold: assert property (p_filt_hold) else $error("filter passed a short pulse");

endmodule : ioxp_glitch_filter

// File: src/ioxp_expander.sv
module ioxp_expander (
  // Clock and reset
  input logic ref_clk,
  input logic rst_n,
  // Serial bus
  input logic scl_in,
  input logic sda_in,
  output ioxp_pkg::ioxp_od_t sda_pin,
  // Address select straps
  input logic addr_select_bit0,
  input logic addr_select_bit1,
  input logic addr_select_bit2,
  // Port lines
  input ioxp_pkg::ioxp_lines_t line_in,
  output ioxp_pkg::ioxp_pinout_t line_pin,
  // Change alert
  output ioxp_pkg::ioxp_od_t alert_pin
);
  import ioxp_pkg::*;

  localparam ioxp_state_t ST_RST = '{
    fsm: S_IDLE,
    outl: {2{OUT_RST}},
    pol: {2{POL_RST}},
    dir: {2{DIR_RST}},
    scl_q: 1'b1,
    sda_q: 1'b1,
    default: '0
  };

  ioxp_state_t st;
  ioxp_state_t next_st;
  logic scl_f;
  logic sda_f;
  logic [SYNC_W-1:0] syn;
  ioxp_lines_t live;
  logic [2:0] addr_sel;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [15:0] diff;

  ////////////////////////////////////////////////////////////////////////////
  // fast-mode margin
  // A 400 kHz bus gives about fifty clocks per half period, far more than
  // the few cycles of synchroniser and filter delay.
  ioxp_glitch_filter u_scl_filt (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .raw(scl_in),
    .filt(scl_f)
  );

  ioxp_glitch_filter u_sda_filt (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .raw(sda_in),
    .filt(sda_f)
  );

  ioxp_sync2 u_pin_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d({addr_select_bit2, addr_select_bit1, addr_select_bit0, line_in}),
    .q(syn)
  );

  assign live = ioxp_lines_t'(syn[15:0]);
  assign addr_sel = syn[18:16];

  assign scl_rise = scl_f & ~st.scl_q;
  assign scl_fall = ~scl_f & st.scl_q;
  assign start_c = scl_f & st.scl_q & st.sda_q & ~sda_f;
  assign stop_c = scl_f & st.scl_q & ~st.sda_q & sda_f;
  assign diff = (live ^ st.snap) & st.dir;

  ////////////////////////////////////////////////////////////////////////////
  // Pair partner: sequential access alternates within a register pair.
  function automatic logic [2:0] pair_next(input logic [2:0] p);
    pair_next = {p[2:1], ~p[0]};
  endfunction : pair_next

  // Loads the byte to send and starts driving its first bit.
  function automatic ioxp_state_t load_byte(input ioxp_state_t s, input ioxp_lines_t lv);
    ioxp_state_t r;
    r = s;
    if (s.ptr[2:1] == REG_IN0[2:1])
    begin
      r.sh = lv[s.ptr[0]] ^ s.pol[s.ptr[0]];
      r.snap[s.ptr[0]] = lv[s.ptr[0]];
    end
    else if (s.ptr[2:1] == REG_OUT0[2:1])
      r.sh = s.outl[s.ptr[0]];
    else if (s.ptr[2:1] == REG_POL0[2:1])
      r.sh = s.pol[s.ptr[0]];
    else
      r.sh = s.dir[s.ptr[0]];
    r.cnt = 4'h0;
    r.fsm = S_TX;
    r.sda_oe = ~r.sh[7];
    load_byte = r;
  endfunction : load_byte

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_st = st;
    next_st.scl_q = scl_f;
    next_st.sda_q = sda_f;
    if (!st.primed)
    begin
      next_st.snap = live;
      next_st.primed = 1'b1;
    end
    next_st.alert = st.primed & (|diff);
    unique case (st.fsm)
      S_IDLE:
      begin
      end
      S_ADDR, S_PTR, S_WDATA:
      begin
        if (scl_rise)
        begin
          next_st.sh = {st.sh[6:0], sda_f};
          next_st.cnt = st.cnt + 4'h1;
        end
        else if (scl_fall && st.cnt == 4'h8)
        begin
          next_st.cnt = 4'h0;
          if (st.fsm == S_ADDR)
          begin
            if (st.sh[7:1] == {ADDR_FIXED, addr_sel})
            begin
              next_st.rw = st.sh[0];
              next_st.sda_oe = 1'b1;
              next_st.fsm = S_ACK_A;
            end
            else
              next_st.fsm = S_IDLE;
          end
          else
          begin
            next_st.sda_oe = 1'b1;
            next_st.fsm = S_ACK_W;
            if (st.fsm == S_PTR)
              next_st.ptr = st.sh[2:0];
            else
            begin
              next_st.ptr = pair_next(st.ptr);
              if (st.ptr[2:1] == REG_OUT0[2:1])
                next_st.outl[st.ptr[0]] = st.sh;
              else if (st.ptr[2:1] == REG_POL0[2:1])
                next_st.pol[st.ptr[0]] = st.sh;
              else if (st.ptr[2:1] == REG_DIR0[2:1])
                next_st.dir[st.ptr[0]] = st.sh;
            end
          end
        end
      end
      S_ACK_A:
      begin
        if (scl_fall)
        begin
          next_st.sda_oe = 1'b0;
          if (st.rw)
            next_st = load_byte(next_st, live);
          else
            next_st.fsm = S_PTR;
        end
      end
      S_ACK_W:
      begin
        if (scl_fall)
        begin
          next_st.sda_oe = 1'b0;
          next_st.fsm = S_WDATA;
        end
      end
      S_TX:
      begin
        if (scl_fall)
        begin
          if (st.cnt == 4'h7)
          begin
            next_st.sda_oe = 1'b0;
            next_st.fsm = S_RACK;
          end
          else
          begin
            next_st.cnt = st.cnt + 4'h1;
            next_st.sh = {st.sh[6:0], 1'b0};
            next_st.sda_oe = ~st.sh[6];
          end
        end
      end
      S_RACK:
      begin
        if (scl_rise)
          next_st.mack = ~sda_f;
        else if (scl_fall)
        begin
          if (st.mack)
          begin
            next_st.ptr = pair_next(st.ptr);
            next_st = load_byte(next_st, live);
          end
          else
            next_st.fsm = S_IDLE;
        end
      end
    endcase
    // A stop or a repeated start always overrides the byte in progress.
    if (stop_c)
    begin
      next_st.fsm = S_IDLE;
      next_st.sda_oe = 1'b0;
    end
    if (start_c)
    begin
      next_st.fsm = S_ADDR;
      next_st.cnt = 4'h0;
      next_st.sda_oe = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= ST_RST;
    else
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // latched outputs
  assign line_pin.out = st.outl;
  assign line_pin.oe = ~st.dir;
  assign sda_pin.out = 1'b0;
  assign sda_pin.oe = st.sda_oe;
  assign alert_pin.out = 1'b0;
  assign alert_pin.oe = st.alert;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_addr_hit;
    st.fsm == S_ADDR && scl_fall && st.cnt == 4'h8 && st.sh[7:1] == {ADDR_FIXED, addr_sel};
  endsequence

  sequence s_wr_byte(logic [2:0] reg_no);
    st.fsm == S_WDATA && scl_fall && st.cnt == 4'h8 && st.ptr == reg_no && !start_c && !stop_c;
  endsequence

  sequence s_rd_start(logic [2:0] reg_no);
    st.fsm == S_ACK_A && scl_fall && st.rw && st.ptr == reg_no && !start_c && !stop_c;
  endsequence

  property p_addr_ack;
    s_addr_hit ##0 (!start_c && !stop_c) |=> st.sda_oe && st.fsm == S_ACK_A;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("matching address not acknowledged");

  property p_addr_miss;
    st.fsm == S_ADDR && scl_fall && st.cnt == 4'h8 && st.sh[7:1] != {ADDR_FIXED, addr_sel}
      |=> !st.sda_oe;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address acknowledged");

  property p_dir_write;
    s_wr_byte(REG_DIR0) |=> line_pin.oe[0] == ~$past(st.sh);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write not applied");

  property p_out_write;
    s_wr_byte(REG_OUT1) |=> line_pin.out[1] == $past(st.sh) && st.ptr == REG_OUT0;
  endproperty
  a_out_write: assert property (p_out_write) else $error("output latch write wrong");

  property p_inv_read;
    s_rd_start(REG_IN1) |=> st.sh == ($past(live[1]) ^ $past(st.pol[1])) && st.fsm == S_TX;
  endproperty
  a_inv_read: assert property (p_inv_read) else $error("input read not inverted by polarity");

  property p_dir_read;
    s_rd_start(REG_DIR0) |=> st.sh == $past(st.dir[0]) && st.sda_oe == ~$past(st.dir[0][7]);
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction readback wrong");

  property p_alert_set;
    st.primed && (|diff) |=> alert_pin.oe;
  endproperty
  a_alert_set: assert property (p_alert_set) else $error("alert missing on input change");

  property p_alert_idle;
    !(|diff) |=> !alert_pin.oe && alert_pin.out == 1'b0;
  endproperty
  a_alert_idle: assert property (p_alert_idle) else $error("alert held without change");

  property p_read_snap;
    s_rd_start(REG_IN0) |=> st.snap[0] == $past(live[0]);
  endproperty
  a_read_snap: assert property (p_read_snap) else $error("input read did not clear change");

  property p_reset_state;
    !st.primed |-> st.fsm == S_IDLE && line_pin.oe == '0 && st.outl == {2{OUT_RST}} && !alert_pin.oe;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset defaults wrong");

  property p_stop_idle;
    stop_c && !start_c |=> st.fsm == S_IDLE && !sda_pin.oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not release bus");

endmodule : ioxp_expander

// File: sim/ioxp_master.sv
module ioxp_master (
  // Bus wires
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // fixed bit period.
  // The bus runs faster than its rated rate to keep runs short.
  // The low phase outlasts the device's five-cycle reply, so its data settles before the clock rises.
  // Data is sampled at the end of the high phase because the device answers several cycles after the fall.
  task automatic bit_io(input logic b, output logic s);
    #50 sda_low = ~b;
    #150 scl = 1'b1;
    #100 s = sda;
    scl = 1'b0;
  endtask : bit_io

  // Serves as repeated start when the clock is already low.
  task automatic start();
    if (scl == 1'b0)
    begin
      #50 sda_low = 1'b0;
      #150 scl = 1'b1;
      #100;
    end
    sda_low = 1'b1;
    #100 scl = 1'b0;
  endtask : start

  task automatic stop();
    #50 sda_low = 1'b1;
    #50 scl = 1'b1;
    #100 sda_low = 1'b0;
    #100;
  endtask : stop

  task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ack, nak);
  endtask : xfer

endmodule : ioxp_master

// File: sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ioxp_pkg::*;

  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] strap = 3'h0;
  ioxp_lines_t ext = '0;
  ioxp_lines_t pins;
  ioxp_pinout_t line_pin;
  ioxp_od_t sda_pin;
  ioxp_od_t alert_pin;
  logic scl;
  logic sda_low;
  wire logic sda = ~(sda_low | sda_pin.oe);
  wire logic alert_w = ~alert_pin.oe;
  int bad_count = 0;
  int n_tests = 0;

  always #12.5 ref_clk = ~ref_clk;
  // Driven lines show the latch, the rest follow the board.
  assign pins = (line_pin.oe & line_pin.out) | (~line_pin.oe & ext);

  ioxp_master ioxp_master_i (.scl(scl), .sda_low(sda_low), .sda(sda));

  ioxp_expander ioxp_expander_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_pin(sda_pin),
    .addr_select_bit0(strap[0]), .addr_select_bit1(strap[1]), .addr_select_bit2(strap[2]),
    .line_in(pins), .line_pin(line_pin), .alert_pin(alert_pin)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [6:0] a, input logic [2:0] r, input logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic n1, n2, n3;
    // Bus changes land just after a clock edge, never on one.
    @(posedge ref_clk);
    #5;
    ioxp_master_i.start();
    ioxp_master_i.xfer({a, 1'b0}, 1'b1, q, n1);
    ioxp_master_i.xfer({5'h00, r}, 1'b1, q, n2);
    ioxp_master_i.xfer(d, 1'b1, q, n3);
    ioxp_master_i.stop();
    nak = n1 | n2 | n3;
  endtask : wr

  task automatic wr_ok(input logic [2:0] r, input logic [7:0] d);
    logic n;
    wr({ADDR_FIXED, strap}, r, d, n);
    check("write ack", n, 1'b0);
  endtask : wr_ok

  task automatic rd(input logic [2:0] r, output logic [7:0] q);
    logic [7:0] x;
    logic n1, n2, n3, n4;
    @(posedge ref_clk);
    #5;
    ioxp_master_i.start();
    ioxp_master_i.xfer({ADDR_FIXED, strap, 1'b0}, 1'b1, x, n1);
    ioxp_master_i.xfer({5'h00, r}, 1'b1, x, n2);
    ioxp_master_i.start();
    ioxp_master_i.xfer({ADDR_FIXED, strap, 1'b1}, 1'b1, x, n3);
    ioxp_master_i.xfer(8'hff, 1'b1, q, n4);
    ioxp_master_i.stop();
    check("read ack", n1 | n2 | n3, 1'b0);
  endtask : rd

  task automatic set_ext(input int p, input logic [7:0] v);
    @(posedge ref_clk);
    ext[p] <= v;
    repeat (20) @(posedge ref_clk);
    #5;
  endtask : set_ext

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] q;
    logic [7:0] exp [2:7] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff};
    check("line oe", line_pin.oe, 16'h0000);
    check("line out", line_pin.out, 16'hffff);
    check("alert", alert_w, 1'b1);
    check("sda drive", sda_pin.out, 1'b0);
    for (int r = 2; r <= 7; r++)
    begin
      rd(r[2:0], q);
      check("reset value", q, exp[r]);
    end
    $display("test reset done");
  endtask : t_reset

  task automatic t_output();
    logic [7:0] q;
    wr_ok(REG_OUT0, 8'h5a);
    check("latch idle", line_pin.oe, 16'h0000);
    wr_ok(REG_DIR0, 8'h00);
    check("line out", line_pin.out[0], 8'h5a);
    check("line oe", line_pin.oe, 16'h00ff);
    rd(REG_OUT0, q);
    check("out readback", q, 8'h5a);
    rd(REG_DIR0, q);
    check("dir readback", q, 8'h00);
    rd(REG_IN0, q);
    check("driven level", q, 8'h5a);
    $display("test output done");
  endtask : t_output

  task automatic t_invert();
    logic [7:0] q;
    set_ext(1, 8'ha5);
    rd(REG_IN1, q);
    check("input level", q, 8'ha5);
    wr_ok(REG_POL1, 8'h0f);
    rd(REG_POL1, q);
    check("pol readback", q, 8'h0f);
    rd(REG_IN1, q);
    check("inverted", q, 8'haa);
    wr_ok(REG_POL1, 8'h00);
    $display("test invert done");
  endtask : t_invert

  task automatic t_alert();
    logic [7:0] q;
    set_ext(1, 8'h3c);
    check("alert set", alert_w, 1'b0);
    check("alert drive", alert_pin.out, 1'b0);
    rd(REG_IN1, q);
    check("alert read", {q, alert_w}, {8'h3c, 1'b1});
    set_ext(1, 8'h3d);
    check("alert again", alert_w, 1'b0);
    set_ext(1, 8'h3c);
    check("alert back", alert_w, 1'b1);
    $display("test alert done");
  endtask : t_alert

  task automatic t_addr();
    logic n;
    @(posedge ref_clk);
    strap <= 3'h5;
    repeat (5) @(posedge ref_clk);
    wr_ok(REG_OUT1, 8'ha5);
    check("strap write", line_pin.out[1], 8'ha5);
    wr({ADDR_FIXED, 3'h2}, REG_OUT1, 8'h11, n);
    check("foreign nak", n, 1'b1);
    check("foreign ignored", line_pin.out[1], 8'ha5);
    $display("test addr done");
  endtask : t_addr

  task automatic t_pair();
    logic [7:0] x;
    logic [7:0] q0;
    logic [7:0] q1;
    logic n1, n2, n3, n4, n5;
    @(posedge ref_clk);
    #5;
    ioxp_master_i.start();
    ioxp_master_i.xfer({ADDR_FIXED, strap, 1'b0}, 1'b1, x, n1);
    ioxp_master_i.xfer({5'h00, REG_OUT0}, 1'b1, x, n2);
    ioxp_master_i.start();
    ioxp_master_i.xfer({ADDR_FIXED, strap, 1'b1}, 1'b1, x, n3);
    // The master acknowledges the first byte, so the pair partner follows.
    ioxp_master_i.xfer(8'hff, 1'b0, q0, n4);
    ioxp_master_i.xfer(8'hff, 1'b1, q1, n5);
    ioxp_master_i.stop();
    check("pair ack", n1 | n2 | n3, 1'b0);
    check("pair read", {q1, q0}, {8'ha5, 8'h5a});
    $display("test pair done");
  endtask : t_pair

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #5;
    t_reset();
    t_output();
    t_invert();
    t_alert();
    t_addr();
    t_pair();
    stop_test();
  end

  // The whole run needs some 220 us; the limit leaves ample room.
  initial
  begin
    #2ms;
    bad_count++;
    stop_test();
  end

endmodule : tb_top
